// ---- rtl/ccpu_params.svh ----
`ifndef CCPU_PARAMS_SVH
`define CCPU_PARAMS_SVH

// ==========================================================
// Register byte offsets
`define CCPU_OFS_PWM_COUNT 8'h00
`define CCPU_OFS_PWM_PERIOD 8'h04
`define CCPU_OFS_PWM_CTRL 8'h08
`define CCPU_OFS_U1_LOW 8'h0C
`define CCPU_OFS_U1_HIGH 8'h10
`define CCPU_OFS_U1_CTRL 8'h14
`define CCPU_OFS_U2_LOW 8'h18
`define CCPU_OFS_U2_HIGH 8'h1C
`define CCPU_OFS_U2_CTRL 8'h20
`define CCPU_OFS_TB_COUNT 8'h24
`define CCPU_OFS_TB_CTRL 8'h28
`define CCPU_OFS_STATUS 8'h2C
`define CCPU_UNIT_STRIDE 8'h0C

// ==========================================================
// Field positions
`define CCPU_CTL_MODE_MSB 3
`define CCPU_CTL_DLOW_MSB 5
`define CCPU_CTL_DLOW_LSB 4
`define CCPU_T2_PRE_MSB 1
`define CCPU_T2_ON_BIT 2
`define CCPU_T2_POST_MSB 6
`define CCPU_T2_POST_LSB 3
`define CCPU_ST_U1_BIT 0
`define CCPU_ST_U2_BIT 1
`define CCPU_ST_OVF_BIT 2
`define CCPU_ST_PWM_BIT 3

// ==========================================================
// Reset values and mode codes
`define CCPU_RST_PERIOD 8'hFF
`define CCPU_RST_BYTE 8'h00
`define CCPU_RST_TB 16'h0000
`define CCPU_TB_MAX 16'hFFFF
`define CCPU_MODE_OFF 4'h0
`define CCPU_MODE_TOGGLE 4'h2
`define CCPU_MODE_SET_HI 4'h8
`define CCPU_MODE_SET_LO 4'h9
`define CCPU_MODE_SWI 4'hA
`define CCPU_MODE_SEV 4'hB

// ==========================================================
// Prescale terminal counts of the fine counter (clocks - 1)
`define CCPU_FINE_DIV1 6'h03
`define CCPU_FINE_DIV4 6'h0F
`define CCPU_FINE_DIV16 6'h3F

`endif

// ---- rtl/ccpu_pkg.sv ----
package ccpu_pkg;
	// Pin action selected by the mode field on a compare match
	typedef enum logic [1:0] {
		CCPU_ACT_NONE,
		CCPU_ACT_HIGH,
		CCPU_ACT_LOW,
		CCPU_ACT_TOGGLE
	} ccpu_act_t;

	// Mode field of a unit control register
	typedef logic [3:0] ccpu_mode_t;
endpackage

// ---- rtl/ccpu_top.sv ----
// Implementation choices: the address map and the AHB-Lite interface to the registers.
`timescale 1ns/1ns
`include "ccpu_params.svh"
// Operation
// R1: Compare 16-bit value against timebase each update
// R2: Match applies pin action and sets flag
// R3: Mode codes select off, compare, capture, PWM; no capture mode here, other codes do nothing
// R4: Units identical except special event action
// R5: Zero control write forces compare latch low
// R6: Software keeps timebase synchronous for compare
// R7: Software-interrupt mode leaves pin untouched
// R8: Unit 1 special event resets timebase
// R9: Unit 2 event resets timebase, starts conversion
// R10: Unit 2 event reset never sets overflow
// R11: Software makes pin an output first
// R12: Software clears control before new prescaler
// R13: PWM mode gives up to 10-bit duty
// R14: Zero control write forces PWM latch low
// R15: Period end clears timer, sets pin, copies
// R16: Postscaler never affects PWM period
// R17: Duty is master byte plus bits 5:4
// R18: Duty writes apply at period end only
// R19: Pin clears when extended duty meets timer
// R20: High time is duty times prescaled clock
// R21: Duty above period keeps pin high
// R22: Timer prescale divides by 1, 4, 16
// R23: Software follows PWM setup order
// R24: Compare and event triggers are one-cycle pulses; a special event at value 0000 repeats every cycle here
module ccpu_top
	import ccpu_pkg::*;
(
	// Clock and reset
	input wire logic hclk,
	input wire logic hresetn,
	// AHB-Lite slave
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic hreadyout,
	output logic hresp,
	output logic [31:0] hrdata,
	// Converter link
	input wire logic adc_enable,
	output logic adc_start,
	// Unit pins and triggers
	output logic unit1_pin,
	output logic unit2_pin,
	output logic [1:0] unit_trigger
);

	// ==========================================================
	// Helper functions
	// Compare modes 0010 and 1000 to 1011
	function automatic logic is_cmp(input ccpu_mode_t m);
		return (m == `CCPU_MODE_TOGGLE) || (m[3:2] == 2'b10);
	endfunction

	// PWM modes 11xx
	function automatic logic is_pwm(input ccpu_mode_t m);
		return m[3:2] == 2'b11;
	endfunction

	// Pin action for a compare mode
	function automatic ccpu_act_t act_of(input ccpu_mode_t m);
		unique case (m)
			`CCPU_MODE_TOGGLE: return CCPU_ACT_TOGGLE;
			`CCPU_MODE_SET_HI: return CCPU_ACT_HIGH;
			`CCPU_MODE_SET_LO: return CCPU_ACT_LOW;
			default: return CCPU_ACT_NONE;
		endcase
	endfunction

	// ==========================================================
	// Bus address phase capture
	logic wr_en_reg;
	logic [7:0] wr_addr_reg;
	logic [31:0] hrdata_reg;
	wire addr_ok = hsel && htrans[1] && hready;
	wire [7:0] a_ofs = haddr[7:0];

	// Write strobes decoded from the data phase
	wire wr_count = wr_en_reg && (wr_addr_reg == `CCPU_OFS_PWM_COUNT);
	wire wr_period = wr_en_reg && (wr_addr_reg == `CCPU_OFS_PWM_PERIOD);
	wire wr_t2ctl = wr_en_reg && (wr_addr_reg == `CCPU_OFS_PWM_CTRL);
	wire wr_tb = wr_en_reg && (wr_addr_reg == `CCPU_OFS_TB_COUNT);
	wire wr_tbctl = wr_en_reg && (wr_addr_reg == `CCPU_OFS_TB_CTRL);
	wire wr_status = wr_en_reg && (wr_addr_reg == `CCPU_OFS_STATUS);

	assign hreadyout = 1'b1;
	assign hresp = 1'b0;
	assign hrdata = hrdata_reg;

	// ==========================================================
	// Shared registers
	logic [7:0] pwm_count_reg;
	logic [7:0] pwm_period_reg;
	logic [6:0] pwm_ctrl_reg;
	logic [5:0] fine_reg;
	logic [3:0] post_reg;
	logic [15:0] tb_reg;
	logic tb_on_reg;
	logic tb_upd_reg;
	logic [3:0] status_reg;
	logic adc_start_reg;

	logic [7:0] val_lo_reg [2];
	logic [7:0] val_hi_reg [2];
	logic [5:0] ctl_reg [2];
	logic [1:0] lat2_reg [2];
	logic pin_reg [2];
	logic [1:0] match;
	logic [1:0] sev;

	// PWM timer prescale, one of 1, 4 or 16
	wire t2_on = pwm_ctrl_reg[`CCPU_T2_ON_BIT];
	wire [1:0] pre = pwm_ctrl_reg[`CCPU_T2_PRE_MSB:0];
	wire [5:0] fine_top = (pre == 2'b00) ? `CCPU_FINE_DIV1 :
		(pre == 2'b01) ? `CCPU_FINE_DIV4 : `CCPU_FINE_DIV16; // R22
	wire tmr_inc = t2_on && (fine_reg == fine_top);
	wire period_end = tmr_inc && (pwm_count_reg == pwm_period_reg); // R15
	// Timer state after this edge; the clear must land on the edge
	// at which the extended timer reaches the duty, not one later
	wire [5:0] fine_nxt = (!t2_on || tmr_inc) ? 6'h00 : fine_reg + 6'h01;
	wire [7:0] count_nxt = period_end ? 8'h00 :
		tmr_inc ? pwm_count_reg + 8'h01 : pwm_count_reg;
	// Two low bits extending the timer for the 10-bit compare
	wire [1:0] fine_low = (pre == 2'b00) ? fine_nxt[1:0] :
		(pre == 2'b01) ? fine_nxt[3:2] : fine_nxt[5:4]; // R19 R20
	wire post_end = post_reg == pwm_ctrl_reg[`CCPU_T2_POST_MSB:
		`CCPU_T2_POST_LSB];

	// Timebase events
	wire tb_run = tb_on_reg && !wr_tb;
	wire sev_any = |sev;
	wire tb_wrap = tb_run && !sev_any && (tb_reg == `CCPU_TB_MAX);

	// Status: hardware sets win over write-one-to-clear
	wire [3:0] st_set = {period_end && post_end, tb_wrap, match}; // R2
	wire [3:0] st_clr = wr_status ? hwdata[3:0] : 4'h0;

	// Read mux of the address phase
	logic [31:0] rd_mux;
	always_comb begin
		rd_mux = 32'h0000_0000;
		unique case (a_ofs)
			`CCPU_OFS_PWM_COUNT: rd_mux[7:0] = pwm_count_reg;
			`CCPU_OFS_PWM_PERIOD: rd_mux[7:0] = pwm_period_reg;
			`CCPU_OFS_PWM_CTRL: rd_mux[6:0] = pwm_ctrl_reg;
			`CCPU_OFS_U1_LOW: rd_mux[7:0] = val_lo_reg[0];
			`CCPU_OFS_U1_HIGH: rd_mux[7:0] = val_hi_reg[0];
			`CCPU_OFS_U1_CTRL: rd_mux[5:0] = ctl_reg[0];
			`CCPU_OFS_U2_LOW: rd_mux[7:0] = val_lo_reg[1];
			`CCPU_OFS_U2_HIGH: rd_mux[7:0] = val_hi_reg[1];
			`CCPU_OFS_U2_CTRL: rd_mux[5:0] = ctl_reg[1];
			`CCPU_OFS_TB_COUNT: rd_mux[15:0] = tb_reg;
			`CCPU_OFS_TB_CTRL: rd_mux[0] = tb_on_reg;
			`CCPU_OFS_STATUS: rd_mux[3:0] = status_reg;
			default: rd_mux = 32'h0000_0000;
		endcase
	end

	// Bus phase registers
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			wr_en_reg <= 1'b0;
			wr_addr_reg <= 8'h00;
			hrdata_reg <= 32'h0000_0000;
		end else begin
			wr_en_reg <= addr_ok && hwrite && (haddr[31:8] == 24'h000000);
			wr_addr_reg <= a_ofs;
			if (addr_ok && !hwrite) begin
				hrdata_reg <= (haddr[31:8] == 24'h000000) ? rd_mux :
					32'h0000_0000;
			end
		end
	end

	// ==========================================================
	// PWM timer: prescaler, counter, postscaler
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			fine_reg <= 6'h00;
			pwm_count_reg <= `CCPU_RST_BYTE;
			pwm_period_reg <= `CCPU_RST_PERIOD;
			pwm_ctrl_reg <= 7'h00;
			post_reg <= 4'h0;
		end else begin
			fine_reg <= fine_nxt;
			if (wr_count) begin
				pwm_count_reg <= hwdata[7:0];
			end else if (period_end) begin
				pwm_count_reg <= 8'h00; // R15
			end else if (tmr_inc) begin
				pwm_count_reg <= pwm_count_reg + 8'h01;
			end
			if (wr_period) begin
				pwm_period_reg <= hwdata[7:0];
			end
			if (wr_t2ctl) begin
				pwm_ctrl_reg <= hwdata[6:0];
			end
			// Postscaler only paces the timer flag
			if (wr_t2ctl) begin
				post_reg <= 4'h0;
			end else if (period_end) begin
				post_reg <= post_end ? 4'h0 : post_reg + 4'h1; // R16
			end
		end
	end

	// ==========================================================
	// Compare timebase and status
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			tb_reg <= `CCPU_RST_TB;
			tb_on_reg <= 1'b0;
			tb_upd_reg <= 1'b0;
			status_reg <= 4'h0;
			adc_start_reg <= 1'b0;
		end else begin
			if (wr_tb) begin
				tb_reg <= hwdata[15:0];
			end else if (sev_any) begin
				tb_reg <= `CCPU_RST_TB; // R8 R9
			end else if (tb_run) begin
				tb_reg <= tb_reg + 16'h0001;
			end
			tb_upd_reg <= wr_tb || sev_any || tb_run; // R1
			if (wr_tbctl) begin
				tb_on_reg <= hwdata[0];
			end
			status_reg <= (status_reg & ~st_clr) | st_set; // R10
			adc_start_reg <= sev[1] && adc_enable; // R9
		end
	end

	assign adc_start = adc_start_reg;
	assign unit_trigger = sev;
	assign unit1_pin = pin_reg[0];
	assign unit2_pin = pin_reg[1];

	// ==========================================================
	// Two identical units
	default clocking cb @(posedge hclk);
	endclocking
	default disable iff (!hresetn);

	for (genvar i = 0; i < 2; i++) begin : g_unit // R4
		wire [7:0] base = 8'(`CCPU_OFS_U1_LOW + i * `CCPU_UNIT_STRIDE);
		wire wr_lo = wr_en_reg && (wr_addr_reg == base);
		wire wr_hi = wr_en_reg && (wr_addr_reg == 8'(base + 8'h04));
		wire wr_ctl = wr_en_reg && (wr_addr_reg == 8'(base + 8'h08));
		wire ccpu_mode_t mode = ctl_reg[i][`CCPU_CTL_MODE_MSB:0];
		wire ccpu_mode_t new_mode = hwdata[`CCPU_CTL_MODE_MSB:0];
		wire pwm = is_pwm(mode); // R3
		wire ccpu_act_t act = act_of(mode);
		// Duty for the coming period, upper byte then bits 5:4
		wire [9:0] duty_next = {val_lo_reg[i],
			ctl_reg[i][`CCPU_CTL_DLOW_MSB:`CCPU_CTL_DLOW_LSB]}; // R17
		wire duty_hit = {val_hi_reg[i], lat2_reg[i]} ==
			{count_nxt, fine_low}; // R19

		// Match on a timebase update, one pulse per match
		assign match[i] = is_cmp(mode) && tb_upd_reg &&
			(tb_reg == {val_hi_reg[i], val_lo_reg[i]}); // R1 R24
		assign sev[i] = match[i] && (mode == `CCPU_MODE_SEV); // R8 R9

		// Value and duty buffer registers
		always_ff @(posedge hclk or negedge hresetn) begin
			if (!hresetn) begin
				val_lo_reg[i] <= `CCPU_RST_BYTE;
				val_hi_reg[i] <= `CCPU_RST_BYTE;
				ctl_reg[i] <= 6'h00;
				lat2_reg[i] <= 2'b00;
			end else begin
				if (wr_lo) begin
					val_lo_reg[i] <= hwdata[7:0];
				end
				if (pwm && period_end) begin
					val_hi_reg[i] <= val_lo_reg[i]; // R15 R18
					lat2_reg[i] <= duty_next[1:0];
				end else if (wr_hi && !pwm) begin
					val_hi_reg[i] <= hwdata[7:0]; // R18
				end
				if (wr_ctl) begin
					ctl_reg[i] <= hwdata[5:0];
				end
			end
		end

		// Output latch shared by compare and PWM
		always_ff @(posedge hclk or negedge hresetn) begin
			if (!hresetn) begin
				pin_reg[i] <= 1'b0;
			end else if (wr_ctl) begin
				pin_reg[i] <= (new_mode == `CCPU_MODE_SET_LO); // R5 R14
			end else if (pwm) begin
				if (period_end) begin
					pin_reg[i] <= duty_next != 10'h000; // R13 R15
				end else if (duty_hit) begin
					pin_reg[i] <= 1'b0; // R19 R21
				end
			end else if (match[i]) begin
				unique case (act) // R2 R7
					CCPU_ACT_HIGH: pin_reg[i] <= 1'b1;
					CCPU_ACT_LOW: pin_reg[i] <= 1'b0;
					CCPU_ACT_TOGGLE: pin_reg[i] <= !pin_reg[i];
					CCPU_ACT_NONE: pin_reg[i] <= pin_reg[i];
				endcase
			end
		end

		// Checks
		sequence s_match;
			match[i] && !wr_ctl;
		endsequence
		sequence s_period;
			pwm && period_end && !wr_ctl && !wr_count;
		endsequence

		a_match_flag: assert property ( // R2
			match[i] |=> status_reg[i])
			else $error("match flag not set");
		a_toggle_pin: assert property ( // R2
			s_match and mode == `CCPU_MODE_TOGGLE
			|=> pin_reg[i] != $past(pin_reg[i]))
			else $error("toggle missed");
		a_swi_pin: assert property ( // R7
			s_match and mode == `CCPU_MODE_SWI
			|=> $stable(pin_reg[i]))
			else $error("pin moved");
		a_ctl_zero: assert property ( // R5
			wr_ctl && hwdata[5:0] == 6'h00
			|=> !pin_reg[i] && mode == `CCPU_MODE_OFF)
			else $error("latch not low");
		a_pwm_period: assert property ( // R15
			s_period |=> pwm_count_reg == 8'h00
			&& val_hi_reg[i] == $past(val_lo_reg[i]))
			else $error("period end wrong");
		a_pwm_set: assert property ( // R15
			s_period and duty_next != 10'h000 |=> pin_reg[i])
			else $error("pin not set");
		a_pwm_zero: assert property ( // R15
			s_period and duty_next == 10'h000 |=> !pin_reg[i])
			else $error("pin set at zero duty");
		a_duty_clear: assert property ( // R19
			pwm && duty_hit && !period_end && !wr_ctl
			|=> !pin_reg[i])
			else $error("pin not cleared");
		a_slave_hold: assert property ( // R18
			pwm && wr_hi && !period_end
			|=> $stable(val_hi_reg[i]))
			else $error("slave byte written in PWM");
		a_off_quiet: assert property ( // R3
			mode == `CCPU_MODE_OFF || pwm |-> !match[i] && !sev[i])
			else $error("match outside compare");
		a_trig_pulse: assert property ( // R24
			sev[i] && !wr_tb
			&& {val_hi_reg[i], val_lo_reg[i]} != 16'h0000
			|=> !sev[i])
			else $error("trigger longer than a cycle");
	end

	a_sev_reset: assert property ( // R8
		sev[0] && !wr_tb |=> tb_reg == 16'h0000)
		else $error("timebase not reset");
	a_tb_write: assert property ( // R8
		wr_tb |=> tb_reg == $past(hwdata[15:0]))
		else $error("bus write lost");
	a_adc_go: assert property ( // R9
		sev[1] && adc_enable |=> adc_start
		##1 !adc_start || $past(sev[1]))
		else $error("no conversion");
	a_adc_quiet: assert property ( // R9
		!(sev[1] && adc_enable) |=> !adc_start)
		else $error("conversion without trigger");
	a_no_ovf: assert property ( // R10
		sev_any && !status_reg[`CCPU_ST_OVF_BIT]
		|=> !status_reg[`CCPU_ST_OVF_BIT])
		else $error("overflow set");
	a_wrap_flag: assert property ( // R10
		tb_wrap |=> status_reg[`CCPU_ST_OVF_BIT])
		else $error("overflow not flagged");

endmodule // ccpu_top

// ---- sim/ccpu_load.sv ----
`timescale 1ns/1ns
// ==========================================================
// External load on a unit pin, measuring pulse shape
module ccpu_load (
	// Clock and reset
	input wire logic hclk,
	input wire logic hresetn,
	// Pin from the unit, seen as a driven output
	input wire logic pin,
	// Last measured high time, period and count of rises
	output int high_len,
	output int period_len,
	output int pulses
);
	int cnt;
	logic last;

	// Count clocks since the last rise
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			cnt <= 0;
			last <= 1'b0;
			high_len <= 0;
			period_len <= 0;
			pulses <= 0;
		end else begin
			last <= pin;
			cnt <= cnt + 1;
			if (pin && !last) begin
				period_len <= cnt;
				cnt <= 1;
				pulses <= pulses + 1;
			end
			if (!pin && last) begin
				high_len <= cnt;
			end
		end
	end
endmodule // ccpu_load

// ---- sim/tb_top.sv ----
`timescale 1ns/1ns
`include "ccpu_params.svh"
`define CHK(g, e) begin checks_done++; if ((g) !== (e)) begin mismatches++; $display("[ERR] t=%0t got=%h exp=%h", $time, g, e); end end
module tb_top;
	import ccpu_pkg::*;
	typedef struct {ccpu_mode_t mode; logic p0; logic p1;} ccpu_row_t;
	logic hclk, hresetn, hsel, hwrite, adc_enable;
	logic [31:0] haddr, hwdata, hrdata, rd;
	logic [1:0] htrans, unit_trigger;
	logic [2:0] hsize;
	logic [7:0] ub;
	logic hreadyout, hresp, adc_start, unit1_pin, unit2_pin;
	int mismatches, checks_done, cyc, high_len, period_len, pulses;
	int i, u, n, k;
	// Compare modes: pin after the control write, pin after a match
	ccpu_row_t rows [4] = '{'{4'h8, 1'b0, 1'b1}, '{4'h9, 1'b1, 1'b0},
		'{4'h2, 1'b0, 1'b1}, '{4'hA, 1'b0, 1'b0}};
	wire upin = (u == 1) ? unit2_pin : unit1_pin;

	ccpu_top dut_u (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
		.haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
		.hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout),
		.hresp(hresp), .hrdata(hrdata), .adc_enable(adc_enable),
		.adc_start(adc_start), .unit1_pin(unit1_pin),
		.unit2_pin(unit2_pin), .unit_trigger(unit_trigger));
	ccpu_load load_u (.hclk(hclk), .hresetn(hresetn), .pin(unit1_pin),
		.high_len(high_len), .period_len(period_len), .pulses(pulses));

	// ==========================================================
	// Clock and cycle limit
	initial begin
		hclk = 1'b0;
		forever #4 hclk = ~hclk;
	end
	initial begin
		cyc = 0;
		forever begin
			@(posedge hclk);
			cyc++;
			if (cyc == 30000) begin
				mismatches++;
				summarize();
			end
		end
	end

	// ==========================================================
	// Bus and helper tasks
	task automatic bus(input logic w, input logic [7:0] a,
		input logic [31:0] d);
		@(posedge hclk);
		hsel <= 1'b1;
		haddr <= {24'h000000, a};
		htrans <= 2'b10;
		hwrite <= w;
		do @(posedge hclk); while (hreadyout !== 1'b1);
		hsel <= 1'b0;
		htrans <= 2'b00;
		hwdata <= d;
		do @(posedge hclk); while (hreadyout !== 1'b1);
		rd = hrdata;
	endtask
	task automatic wtrig(input int b);
		for (n = 0; n < 200; n++) begin
			@(negedge hclk);
			if (unit_trigger[b] === 1'b1) break;
		end
	endtask
	task automatic pwm(input logic [7:0] tc, input logic [7:0] m,
		input logic [1:0] lo, input int hi, input int per);
		bus(1'b1, `CCPU_OFS_U1_LOW, {24'h000000, m});
		bus(1'b1, `CCPU_OFS_PWM_CTRL, {24'h000000, tc});
		bus(1'b1, `CCPU_OFS_U1_CTRL, {26'h0000000, lo, 4'hC});
		n = pulses;
		for (k = 0; k < 3000 && pulses < n + 3; k++) @(posedge hclk);
		`CHK(high_len, hi)
		`CHK(period_len, per)
	endtask
	task summarize;
		$display("mismatches=%0d checks_done=%0d", mismatches, checks_done);
		if (mismatches == 0 && checks_done > 0) $display("STATUS OK");
		else $display("STATUS NOT OK");
		$finish;
	endtask

	// ==========================================================
	// Main sequence
	initial begin
		hsel = 1'b0;
		haddr = 32'h00000000;
		htrans = 2'b00;
		hwrite = 1'b0;
		hsize = 3'h2;
		hwdata = 32'h00000000;
		adc_enable = 1'b0;
		hresetn = 1'b0;
		mismatches = 0;
		checks_done = 0;
		u = 0;
		repeat (20) @(posedge hclk);
		`CHK({unit1_pin, unit2_pin, adc_start, unit_trigger}, 5'h00)
		hresetn <= 1'b1;
		// Reset values, with an unmapped write dropped
		bus(1'b1, 8'h30, 32'hFFFFFFFF);
		for (i = 0; i <= 8'h30; i += 4) begin
			bus(1'b0, i[7:0], 32'h00000000);
			`CHK(rd, (i == 4) ? 32'h000000FF : 32'h00000000)
		end
		// Compare rows on both units
		bus(1'b1, `CCPU_OFS_TB_CTRL, 32'h00000001);
		bus(1'b1, `CCPU_OFS_TB_COUNT, 32'h00001000);
		for (u = 0; u < 2; u++) begin
			ub = (u == 1) ? `CCPU_UNIT_STRIDE : 8'h00;
			bus(1'b1, `CCPU_OFS_U1_LOW + ub, 32'h00000010);
			for (i = 0; i < 4; i++) begin
				bus(1'b1, `CCPU_OFS_STATUS, 32'h0000000F);
				bus(1'b1, `CCPU_OFS_U1_CTRL + ub, 32'h00000000);
				bus(1'b1, `CCPU_OFS_U1_CTRL + ub, {28'h0000000, rows[i].mode});
				@(negedge hclk);
				`CHK(upin, rows[i].p0)
				bus(1'b1, `CCPU_OFS_TB_COUNT, 32'h00000000);
				repeat (40) @(posedge hclk);
				`CHK(upin, rows[i].p1)
				bus(1'b0, `CCPU_OFS_STATUS, 32'h00000000);
				`CHK(rd[u], 1'b1)
				`CHK(rd[1 - u], 1'b0)
			end
			bus(1'b1, `CCPU_OFS_U1_CTRL + ub, 32'h00000000);
			@(negedge hclk);
			`CHK(upin, 1'b0)
		end
		// Special events of unit 1, then unit 2 with and without converter
		bus(1'b1, `CCPU_OFS_U1_LOW, 32'h00000020);
		bus(1'b1, `CCPU_OFS_U1_CTRL, 32'h0000000B);
		bus(1'b1, `CCPU_OFS_TB_COUNT, 32'h00000000);
		wtrig(0);
		`CHK(unit_trigger[0], 1'b1)
		@(negedge hclk);
		`CHK(unit_trigger[0], 1'b0)
		`CHK(adc_start, 1'b0)
		bus(1'b0, `CCPU_OFS_TB_COUNT, 32'h00000000);
		`CHK(rd < 32'h00000010, 1'b1)
		bus(1'b1, `CCPU_OFS_U1_CTRL, 32'h00000000);
		adc_enable <= 1'b1;
		bus(1'b1, `CCPU_OFS_STATUS, 32'h0000000F);
		bus(1'b1, `CCPU_OFS_U2_LOW, 32'h00000020);
		bus(1'b1, `CCPU_OFS_U2_CTRL, 32'h0000000B);
		bus(1'b1, `CCPU_OFS_TB_COUNT, 32'h00000000);
		wtrig(1);
		`CHK(unit_trigger[1], 1'b1)
		@(negedge hclk);
		`CHK(adc_start, 1'b1)
		`CHK(unit_trigger[1], 1'b0)
		bus(1'b0, `CCPU_OFS_STATUS, 32'h00000000);
		`CHK(rd[2:1], 2'b01)
		adc_enable <= 1'b0;
		wtrig(1);
		@(negedge hclk);
		`CHK(adc_start, 1'b0)
		// Event at the top count: reset, no overflow
		bus(1'b1, `CCPU_OFS_U2_HIGH, 32'h000000FF);
		bus(1'b1, `CCPU_OFS_U2_LOW, 32'h000000FF);
		bus(1'b1, `CCPU_OFS_STATUS, 32'h0000000F);
		bus(1'b1, `CCPU_OFS_TB_COUNT, 32'h0000FFF0);
		wtrig(1);
		@(negedge hclk);
		bus(1'b0, `CCPU_OFS_STATUS, 32'h00000000);
		`CHK(rd[2:1], 2'b01)
		bus(1'b1, `CCPU_OFS_U2_CTRL, 32'h00000000);
		// Plain wrap of the timebase does raise overflow
		bus(1'b1, `CCPU_OFS_TB_COUNT, 32'h0000FFF0);
		repeat (40) @(posedge hclk);
		bus(1'b0, `CCPU_OFS_STATUS, 32'h00000000);
		`CHK(rd[2], 1'b1)
		// PWM at each prescale, postscale set in one case
		bus(1'b1, `CCPU_OFS_PWM_PERIOD, 32'h00000003);
		pwm(8'h04, 8'h02, 2'b00, 8, 16);
		pwm(8'h7D, 8'h02, 2'b01, 36, 64);
		pwm(8'h06, 8'h01, 2'b11, 112, 256);
		bus(1'b1, `CCPU_OFS_U1_HIGH, 32'h00000055);
		bus(1'b0, `CCPU_OFS_U1_HIGH, 32'h00000000);
		`CHK(rd, 32'h00000001)
		// Zero duty, then duty above period, then control cleared
		bus(1'b1, `CCPU_OFS_PWM_CTRL, 32'h00000004);
		bus(1'b1, `CCPU_OFS_U1_LOW, 32'h00000000);
		bus(1'b1, `CCPU_OFS_U1_CTRL, 32'h0000000C);
		repeat (300) @(posedge hclk);
		k = 0;
		repeat (64) begin
			@(negedge hclk);
			if (unit1_pin !== 1'b0) k++;
		end
		`CHK(k, 0)
		bus(1'b1, `CCPU_OFS_U1_LOW, 32'h00000010);
		repeat (40) @(posedge hclk);
		k = 0;
		repeat (64) begin
			@(negedge hclk);
			if (unit1_pin !== 1'b1) k++;
		end
		`CHK(k, 0)
		bus(1'b1, `CCPU_OFS_U1_CTRL, 32'h00000000);
		@(negedge hclk);
		`CHK(unit1_pin, 1'b0)
		summarize();
	end
endmodule // tb_top
